// ### src/loop_cfg_defines.vh
// Register offsets, field positions and timing constants for the loop configuration block
`ifndef LOOP_CFG_DEFINES_VH
`define LOOP_CFG_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_LOOP1_LOCK_DETECT_CTRL 8'h28
`define ADDR_LOOP1_REF_SWITCH_CTRL  8'h29
`define ADDR_LOOP1_HOLDOFF_TIME     8'h2A
`define ADDR_LOOP2_MISC_RESERVED_A  8'h31
`define ADDR_LOOP2_DOUBLER_CTRL     8'h32
`define ADDR_LOOP2_REF_DIV_LOW      8'h33
`define ADDR_LOOP2_REF_DIV_HIGH     8'h34
`define ADDR_LOOP2_FB_DIV_LOW       8'h35
`define ADDR_LOOP2_FB_DIV_HIGH      8'h36
`define ADDR_LOOP2_PUMP_CURRENT     8'h37
`define ADDR_LOOP2_MISC_RESERVED_B  8'h3C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LD_USE_SLIP_BIT   5
`define LD_DEPTH_MSB      4
`define LD_DEPTH_LSB      0
`define RS_DEB_BYPASS_BIT 5
`define RS_MANUAL_MSB     4
`define RS_MANUAL_LSB     3
`define RS_HOLD_DAC_BIT   2
`define RS_REVERT_BIT     1
`define RS_AUTO_BIT       0
`define DBL_BYPASS_BIT    0
`define RDIV_HIGH_MSB     3
`define PUMP_MSB          3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define REG8_RESET        8'h00
`define RDIV_ONE          12'h001
`define CNT_ZERO          33'h000000000
`define CNT_ONE           33'h000000001
`define DEBOUNCE_CYCLES   16
`define DEBOUNCE_CNT_W    5

`endif

// ### src/sel_debounce.v
// Debounce filter: output follows input once it has held steady for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
`include "loop_cfg_defines.vh"

module sel_debounce #(
    parameter integer WIDTH = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Filter path
    input  wire [WIDTH-1:0] d,
    input  wire             bypass,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0]             last_r;
    reg [`DEBOUNCE_CNT_W-1:0]   cnt_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= {WIDTH{1'b0}};
            cnt_r  <= {`DEBOUNCE_CNT_W{1'b0}};
            q      <= {WIDTH{1'b0}};
        end else begin
            last_r <= d;
            if (bypass) begin
                cnt_r <= {`DEBOUNCE_CNT_W{1'b0}};
                q     <= d;
            end else if (d != last_r) begin
                cnt_r <= {`DEBOUNCE_CNT_W{1'b0}};
            end else if (cnt_r == `DEBOUNCE_CYCLES - 1) begin
                q <= d;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule // sel_debounce
`default_nettype wire

// ### src/dual_loop_ref_switch_config.v
// Configuration registers, lock qualification and reference switching for a dual-loop jitter attenuator
//
// Behaviour
// - Slip bit selects slip indicator for lock
// - Lock needs two-to-depth-field common-rate cycles
// - Debouncer bypass skips filter on selections
// - Manual field picks reference when not auto
// - Holdover tristates pump or uses DAC
// - Reversion returns to highest-priority available reference
// - Auto mode follows loss status and priority
// - Holdover waits two-to-holdoff-field cycles first; holdoff fields above 32 never time out
// - Zero holdoff switches to next reference directly
// - Doubler in path at 0, bypassed at 1
// - Reference divider twelve bits, split low/high
// - Divider values zero and one divide by one
// - Feedback divider sixteen bits, two consecutive bytes
// - Four-bit pump current level, 160 uA steps
`timescale 1ns/1ps
`default_nettype none
`include "loop_cfg_defines.vh"

module dual_loop_ref_switch_config (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        RESET_N,
    // Register port
    input  wire [7:0]  REG_ADDR,
    input  wire [7:0]  REG_WDATA,
    input  wire        REG_WE,
    input  wire        REG_RE,
    output reg  [7:0]  REG_RDATA,
    // Reference status pins
    input  wire [3:0]  SIGNAL_LOSS_DETECT,
    input  wire [7:0]  REF_PRIORITY,
    input  wire        COMMON_RATE_TICK,
    input  wire        PHASE_IN_WINDOW,
    input  wire        CYCLE_SLIP,
    input  wire        GENERAL_INPUT_PIN_HOLDOVER,
    // First loop control
    output reg  [1:0]  REF_SEL,
    output reg         HOLDOVER,
    output reg         FIRST_LOOP_PUMP_TRISTATE,
    output reg         HOLDOVER_DAC_EN,
    output reg         FIRST_LOOP_LOCKED,
    // Second loop control
    output reg         DOUBLER_EN,
    output reg  [11:0] SECOND_LOOP_REF_RATIO,
    output reg  [15:0] SECOND_LOOP_FB_DIV,
    output reg  [3:0]  PUMP_CURRENT_LEVEL
);

    // ----------------------------------------------------------------
    // Switching states
    // ----------------------------------------------------------------
    localparam [1:0] ST_TRACK   = 2'b00;
    localparam [1:0] ST_HOLDOFF = 2'b01;
    localparam [1:0] ST_SEEK    = 2'b10;

    // Count has reached two raised to exp; exponents past 32 never report reached
    function pow2_reached;
        input [32:0] cnt;
        input [7:0]  exp;
        begin
            if (exp > 8'd32)
                pow2_reached = 1'b0;
            else
                pow2_reached = (cnt >= (`CNT_ONE << exp[5:0]));
        end
    endfunction

    // Highest-priority reference without loss of signal; valid flag in bit 2
    function [2:0] best_ref;
        input [7:0] prio;
        input [3:0] signal_loss_detect;
        integer i;
        reg [1:0] cand;
        begin
            best_ref = 3'b000;
            cand     = 2'b00;
            for (i = 3; i >= 0; i = i - 1) begin
                cand = prio[2*i +: 2];
                if (!signal_loss_detect[cand])
                    best_ref = {1'b1, cand};
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    reg        rst_meta_r;
    reg        rst_sync_r;
    wire       rst_n = rst_sync_r;
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    reg [15:0] pin_meta_r;
    reg [15:0] pin_sync_r;
    reg        tick_d_r;
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_r <= 16'h0000;
            pin_sync_r <= 16'h0000;
            tick_d_r   <= 1'b0;
        end else begin
            pin_meta_r <= {SIGNAL_LOSS_DETECT, REF_PRIORITY, COMMON_RATE_TICK,
                           PHASE_IN_WINDOW, CYCLE_SLIP, GENERAL_INPUT_PIN_HOLDOVER};
            pin_sync_r <= pin_meta_r;
            tick_d_r   <= pin_sync_r[3];
        end
    end
    wire [3:0] los_s      = pin_sync_r[15:12];
    wire [7:0] prio_s     = pin_sync_r[11:4];
    wire       tick       = pin_sync_r[3] & ~tick_d_r;
    wire       in_window  = pin_sync_r[2];
    wire       slip       = pin_sync_r[1];
    wire       gpi_hold_s = pin_sync_r[0];

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    reg [5:0]  lock_ctrl_r;
    reg [5:0]  switch_ctrl_r;
    reg [7:0]  holdoff_r;
    reg [7:0]  misc_a_r;
    reg        dbl_bypass_r;
    reg [7:0]  rdiv_low_r;
    reg [3:0]  rdiv_high_r;
    reg [7:0]  fbdiv_low_r;
    reg [7:0]  fbdiv_high_r;
    reg [3:0]  pump_r;
    reg [7:0]  misc_b_r;

    // Reserved bits of the field registers are not stored and read back as zero; 0x31 and 0x3C keep all eight bits
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            lock_ctrl_r   <= 6'h00;
            switch_ctrl_r <= 6'h00;
            holdoff_r     <= `REG8_RESET;
            misc_a_r      <= `REG8_RESET;
            dbl_bypass_r  <= 1'b0;
            rdiv_low_r    <= `REG8_RESET;
            rdiv_high_r   <= 4'h0;
            fbdiv_low_r   <= `REG8_RESET;
            fbdiv_high_r  <= `REG8_RESET;
            pump_r        <= 4'h0;
            misc_b_r      <= `REG8_RESET;
        end else if (REG_WE) begin
            case (REG_ADDR)
                `ADDR_LOOP1_LOCK_DETECT_CTRL: lock_ctrl_r   <= REG_WDATA[5:0];
                `ADDR_LOOP1_REF_SWITCH_CTRL:  switch_ctrl_r <= REG_WDATA[5:0];
                `ADDR_LOOP1_HOLDOFF_TIME:     holdoff_r     <= REG_WDATA;
                `ADDR_LOOP2_MISC_RESERVED_A:  misc_a_r      <= REG_WDATA;
                `ADDR_LOOP2_DOUBLER_CTRL:     dbl_bypass_r  <= REG_WDATA[`DBL_BYPASS_BIT];
                `ADDR_LOOP2_REF_DIV_LOW:      rdiv_low_r    <= REG_WDATA;
                `ADDR_LOOP2_REF_DIV_HIGH:     rdiv_high_r   <= REG_WDATA[`RDIV_HIGH_MSB:0];
                `ADDR_LOOP2_FB_DIV_LOW:       fbdiv_low_r   <= REG_WDATA;
                `ADDR_LOOP2_FB_DIV_HIGH:      fbdiv_high_r  <= REG_WDATA;
                `ADDR_LOOP2_PUMP_CURRENT:     pump_r        <= REG_WDATA[`PUMP_MSB:0];
                `ADDR_LOOP2_MISC_RESERVED_B:  misc_b_r      <= REG_WDATA;
                default: ;
            endcase
        end
    end
    reg [7:0] rdata_nxt;
    always @* begin
        case (REG_ADDR)
            `ADDR_LOOP1_LOCK_DETECT_CTRL: rdata_nxt = {2'b00, lock_ctrl_r};
            `ADDR_LOOP1_REF_SWITCH_CTRL:  rdata_nxt = {2'b00, switch_ctrl_r};
            `ADDR_LOOP1_HOLDOFF_TIME:     rdata_nxt = holdoff_r;
            `ADDR_LOOP2_MISC_RESERVED_A:  rdata_nxt = misc_a_r;
            `ADDR_LOOP2_DOUBLER_CTRL:     rdata_nxt = {7'h00, dbl_bypass_r};
            `ADDR_LOOP2_REF_DIV_LOW:      rdata_nxt = rdiv_low_r;
            `ADDR_LOOP2_REF_DIV_HIGH:     rdata_nxt = {4'h0, rdiv_high_r};
            `ADDR_LOOP2_FB_DIV_LOW:       rdata_nxt = fbdiv_low_r;
            `ADDR_LOOP2_FB_DIV_HIGH:      rdata_nxt = fbdiv_high_r;
            `ADDR_LOOP2_PUMP_CURRENT:     rdata_nxt = {4'h0, pump_r};
            `ADDR_LOOP2_MISC_RESERVED_B:  rdata_nxt = misc_b_r;
            default:                      rdata_nxt = 8'h00;
        endcase
    end
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n)
            REG_RDATA <= 8'h00;
        else if (REG_RE)
            REG_RDATA <= rdata_nxt;
    end
    wire       use_slip   = lock_ctrl_r[`LD_USE_SLIP_BIT];
    wire [4:0] depth_exp  = lock_ctrl_r[`LD_DEPTH_MSB:`LD_DEPTH_LSB];
    wire       deb_bypass = switch_ctrl_r[`RS_DEB_BYPASS_BIT];
    wire [1:0] manual_sel = switch_ctrl_r[`RS_MANUAL_MSB:`RS_MANUAL_LSB];
    wire       hold_dac   = switch_ctrl_r[`RS_HOLD_DAC_BIT];
    wire       revert_en  = switch_ctrl_r[`RS_REVERT_BIT];
    wire       auto_en    = switch_ctrl_r[`RS_AUTO_BIT];

    // ----------------------------------------------------------------
    // Debounced manual selection and holdover pin
    // ----------------------------------------------------------------
    wire [2:0] deb_q;
    // Glitches on a manual change would otherwise hop the loop between inputs
    sel_debounce #(
        .WIDTH (3)
    ) u_sel_debounce (
        .clk    (SYS_CLK),
        .rst_n  (rst_n),
        .d      ({gpi_hold_s, manual_sel}),
        .bypass (deb_bypass),
        .q      (deb_q)
    );
    wire [1:0] manual_q = deb_q[1:0];
    wire       pin_hold = deb_q[2];
    // ----------------------------------------------------------------
    // Lock detect qualification
    // ----------------------------------------------------------------
    reg [32:0] lock_cnt_r;
    wire       lock_qual = use_slip ? ~slip : in_window;
    wire       lock_hit  = pow2_reached(lock_cnt_r, {3'b000, depth_exp});

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_r        <= `CNT_ZERO;
            FIRST_LOOP_LOCKED <= 1'b0;
        end else begin
            if (!lock_qual) begin
                lock_cnt_r        <= `CNT_ZERO;
                FIRST_LOOP_LOCKED <= 1'b0;
            end else begin
                if (tick && !lock_hit)
                    lock_cnt_r <= lock_cnt_r + `CNT_ONE;
                FIRST_LOOP_LOCKED <= lock_hit;
            end
        end
    end

    // ----------------------------------------------------------------
    // Automatic reference switching
    // ----------------------------------------------------------------
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [1:0]  auto_ref_r;
    reg [1:0]  auto_ref_nxt;
    reg [32:0] hold_cnt_r;
    reg        hold_clr;

    wire [2:0] best      = best_ref(prio_s, los_s);
    wire       cur_lost  = los_s[auto_ref_r];
    wire       hold_done = pow2_reached(hold_cnt_r, holdoff_r);

    always @* begin
        state_nxt    = state_r;
        auto_ref_nxt = auto_ref_r;
        hold_clr     = 1'b0;
        case (state_r)
            ST_TRACK: begin
                if (cur_lost) begin
                    hold_clr = 1'b1;
                    if (holdoff_r == 8'h00)
                        state_nxt = ST_SEEK;
                    else
                        state_nxt = ST_HOLDOFF;
                end else if (revert_en && best[2] && best[1:0] != auto_ref_r) begin
                    auto_ref_nxt = best[1:0];
                end
            end
            ST_HOLDOFF: begin
                if (!cur_lost)
                    state_nxt = ST_TRACK;
                else if (hold_done)
                    state_nxt = ST_SEEK;
            end
            ST_SEEK: begin
                if (best[2]) begin
                    auto_ref_nxt = best[1:0];
                    state_nxt    = ST_TRACK;
                end
            end
            default: state_nxt = ST_TRACK;
        endcase
        if (!auto_en) begin
            state_nxt    = ST_TRACK;
            auto_ref_nxt = manual_q;
        end
    end

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_TRACK;
            auto_ref_r <= 2'b00;
            hold_cnt_r <= `CNT_ZERO;
        end else begin
            state_r    <= state_nxt;
            auto_ref_r <= auto_ref_nxt;
            if (hold_clr)
                hold_cnt_r <= `CNT_ZERO;
            else if (state_r == ST_HOLDOFF && tick && !hold_done)
                hold_cnt_r <= hold_cnt_r + `CNT_ONE;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    wire in_hold = pin_hold || (auto_en && state_r != ST_TRACK);

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REF_SEL                  <= 2'b00;
            HOLDOVER                 <= 1'b0;
            FIRST_LOOP_PUMP_TRISTATE <= 1'b0;
            HOLDOVER_DAC_EN          <= 1'b0;
            DOUBLER_EN               <= 1'b0;
            SECOND_LOOP_REF_RATIO    <= `RDIV_ONE;
            SECOND_LOOP_FB_DIV       <= 16'h0000;
            PUMP_CURRENT_LEVEL       <= 4'h0;
        end else begin
            REF_SEL                  <= auto_en ? auto_ref_r : manual_q;
            HOLDOVER                 <= in_hold;
            FIRST_LOOP_PUMP_TRISTATE <= in_hold & ~hold_dac;
            HOLDOVER_DAC_EN          <= in_hold & hold_dac;
            DOUBLER_EN               <= ~dbl_bypass_r;
            if ({rdiv_high_r, rdiv_low_r} == 12'h000)
                SECOND_LOOP_REF_RATIO <= `RDIV_ONE;
            else
                SECOND_LOOP_REF_RATIO <= {rdiv_high_r, rdiv_low_r};
            SECOND_LOOP_FB_DIV       <= {fbdiv_high_r, fbdiv_low_r};
            PUMP_CURRENT_LEVEL       <= pump_r;
        end
    end

endmodule // dual_loop_ref_switch_config
`default_nettype wire

// ### test/ref_source_model.sv
// Behavioural reference source: common-rate strobe, loss status and loop phase flags
`timescale 1ns/1ps
`default_nettype none
module ref_source_model #(
    parameter int HALF_NS = 100
) (
    // Scenario controls
    input  wire logic [3:0] lost,
    input  wire logic       win,
    input  wire logic       slip,
    // Toward the block
    output logic            tick,
    output logic [3:0]      signal_loss_detect,
    output logic            phase_ok,
    output logic            slip_seen,
    output int              count
);
    // Free-running common rate; odd offset keeps it out of phase with the system clock
    initial begin
        tick = 0;
        count = 0;
        #3;
        forever begin
            #HALF_NS tick = ~tick;
            if (tick) count++;
        end
    end
    // Detectors answer a little late and asynchronously
    assign #7 signal_loss_detect = lost;
    assign #7 phase_ok = win;
    assign #7 slip_seen = slip;
endmodule // ref_source_model
`default_nettype wire

// ### test/loop_cfg_checker.sv
// Concurrent checks on the loop configuration block's ports
`timescale 1ns/1ps
`default_nettype none
module loop_cfg_checker (
    input wire logic        SYS_CLK,
    input wire logic        RESET_N,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WE,
    input wire logic        REG_RE,
    input wire logic [7:0]  REG_RDATA,
    input wire logic [1:0]  REF_SEL,
    input wire logic        HOLDOVER,
    input wire logic        FIRST_LOOP_PUMP_TRISTATE,
    input wire logic        HOLDOVER_DAC_EN,
    input wire logic        FIRST_LOOP_LOCKED,
    input wire logic        DOUBLER_EN,
    input wire logic [11:0] SECOND_LOOP_REF_RATIO,
    input wire logic [15:0] SECOND_LOOP_FB_DIV,
    input wire logic [3:0]  PUMP_CURRENT_LEVEL
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    // Written fields reach the outputs two edges after the strobe
    a_pump_write: assert property (REG_WE && REG_ADDR == 8'h37 |-> ##2
        PUMP_CURRENT_LEVEL == $past(REG_WDATA[3:0], 2)) else $error("pump level not updated");
    a_fb_low: assert property (REG_WE && REG_ADDR == 8'h35 |-> ##2
        SECOND_LOOP_FB_DIV[7:0] == $past(REG_WDATA, 2)) else $error("feedback low byte wrong");
    a_fb_high: assert property (REG_WE && REG_ADDR == 8'h36 |-> ##2
        SECOND_LOOP_FB_DIV[15:8] == $past(REG_WDATA, 2)) else $error("feedback high byte wrong");
    a_ratio_low: assert property (REG_WE && REG_ADDR == 8'h33 && REG_WDATA > 8'h01 |-> ##2
        SECOND_LOOP_REF_RATIO[7:0] == $past(REG_WDATA, 2)) else $error("ratio low byte wrong");
    a_ratio_high: assert property (REG_WE && REG_ADDR == 8'h34 && REG_WDATA[3:0] != 4'h0 |-> ##2
        SECOND_LOOP_REF_RATIO[11:8] == $past(REG_WDATA[3:0], 2)) else $error("ratio high bits wrong");
    a_ratio_nonzero: assert property (SECOND_LOOP_REF_RATIO != 12'h000)
        else $error("reference ratio of zero");
    a_doubler_write: assert property (REG_WE && REG_ADDR == 8'h32 |-> ##2
        DOUBLER_EN == !$past(REG_WDATA[0], 2)) else $error("doubler enable wrong");
    a_unmapped_zero: assert property (REG_RE && !(REG_ADDR inside {[8'h28:8'h2A], [8'h31:8'h37], 8'h3C})
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    a_pump_excl: assert property (!(FIRST_LOOP_PUMP_TRISTATE && HOLDOVER_DAC_EN))
        else $error("tristate and DAC both on");
    a_hold_mode: assert property ($rose(HOLDOVER) |-> ##[0:2] (FIRST_LOOP_PUMP_TRISTATE ^ HOLDOVER_DAC_EN))
        else $error("holdover without pump mode");
    c_holdover: cover property ($rose(HOLDOVER));
    c_locked: cover property ($rose(FIRST_LOOP_LOCKED));
    c_switch: cover property ($changed(REF_SEL));
endmodule // loop_cfg_checker
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the loop configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 0, rst_n = 0, we = 0, re = 0, hold_pin = 0, win = 0, slip = 0;
    logic [7:0]  addr = 0, wdata = 0, prio = 0, rdata;
    logic [3:0]  lost = 0, signal_loss_detect, pump;
    logic [1:0]  sel;
    logic        crt, piw, cs, hov, tri_o, dac, locked, dbl;
    logic [11:0] ratio;
    logic [15:0] fbd;
    logic [31:0] seed = 32'hD511;
    int          bad_count = 0, tests_run = 0, ticks, t0;
    logic [7:0]  sh [0:255];
    logic [7:0]  adr [0:11] = '{8'h28, 8'h29, 8'h2A, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3C, 8'h30};
    logic [7:0]  msk [0:11] = '{8'h3F, 8'h3F, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00};

    always #5 clk = ~clk;

    ref_source_model ref_u (.lost(lost), .win(win), .slip(slip), .tick(crt), .signal_loss_detect(signal_loss_detect), .phase_ok(piw),
        .slip_seen(cs), .count(ticks));
    dual_loop_ref_switch_config dut_u (.SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .SIGNAL_LOSS_DETECT(signal_loss_detect), .REF_PRIORITY(prio),
        .COMMON_RATE_TICK(crt), .PHASE_IN_WINDOW(piw), .CYCLE_SLIP(cs), .GENERAL_INPUT_PIN_HOLDOVER(hold_pin),
        .REF_SEL(sel), .HOLDOVER(hov), .FIRST_LOOP_PUMP_TRISTATE(tri_o), .HOLDOVER_DAC_EN(dac),
        .FIRST_LOOP_LOCKED(locked), .DOUBLER_EN(dbl), .SECOND_LOOP_REF_RATIO(ratio),
        .SECOND_LOOP_FB_DIV(fbd), .PUMP_CURRENT_LEVEL(pump));

    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Shadow keeps only the bits set in msk, none for 0x31 and 0x3C; unmapped places store nothing
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1;
        @(posedge clk);
        we <= 0;
        for (int i = 0; i < 12; i++) if (adr[i] == a) sh[a] = d & msk[i];
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        re <= 1;
        @(posedge clk);
        re <= 0;
        @(posedge clk);
        cmp("reg_read", sh[a], rdata);
    endtask
    task automatic chk_out;
        logic [11:0] r;
        r = {sh[8'h34][3:0], sh[8'h33]};
        cmp("ratio", r == 0 ? 1 : r, ratio);
        cmp("fb_div", {sh[8'h36], sh[8'h35]}, fbd);
        cmp("pump", sh[8'h37][3:0], pump);
        cmp("doubler", !sh[8'h32][0], dbl);
    endtask
    task automatic wait_sel(input logic [1:0] e, input int lim);
        for (int k = 0; k < lim && sel !== e; k++) @(posedge clk);
        cmp("ref_sel", e, sel);
    endtask
    task automatic conclude;
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        conclude;
    end

    initial begin
        for (int i = 0; i < 256; i++) sh[i] = 8'h00;
        step(3);
        rst_n <= 1;
        step(3);
        for (int i = 0; i < 12; i++) rd(adr[i]);
        // Ratio boundaries 0, 1 and full scale, then random traffic
        for (int k = 0; k < 3; k++) begin
            wr(8'h33, k == 2 ? 8'hFF : 8'(k));
            wr(8'h34, k == 2 ? 8'h0F : 8'h00);
            step(3);
            chk_out;
        end
        repeat (8) begin
            for (int i = 0; i < 12; i++) wr(adr[i], xs() & (i == 11 ? 8'hFF : msk[i]));
            for (int i = 0; i < 12; i++) rd(adr[i]);
            step(3);
            chk_out;
        end
        // Manual selection, bypassed then filtered
        wr(8'h2A, 8'h00);
        wr(8'h28, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(8'h29, 8'(8'h20 | (m << 3)));
            step(6);
            cmp("manual_sel", m, sel);
        end
        wr(8'h29, 8'h08);
        step(4);
        cmp("filtered_sel", 3, sel);
        step(30);
        cmp("debounced_sel", 1, sel);
        // Holdover pin with each pump mode
        wr(8'h29, 8'h20);
        hold_pin <= 1;
        step(8);
        cmp("hold_tri", 3'b110, {hov, tri_o, dac});
        wr(8'h29, 8'h24);
        step(4);
        cmp("hold_dac", 3'b101, {hov, tri_o, dac});
        hold_pin <= 0;
        step(8);
        cmp("hold_off", 0, hov);
        // Automatic switching: priority 3,2,1,0
        prio <= 8'h1B;
        wr(8'h29, 8'h23);
        wait_sel(3, 40);
        lost <= 4'h8;
        wait_sel(2, 7);
        lost <= 4'h0;
        wait_sel(3, 40);
        wr(8'h2A, 8'h02);
        lost <= 4'h8;
        for (int k = 0; k < 20 && hov !== 1'b1; k++) @(posedge clk);
        cmp("holdoff_hold", 1, hov);
        t0 = ticks;
        wait_sel(2, 400);
        cmp("holdoff_len", 1, (ticks - t0) inside {[3:4]});
        // Revert off: a recovered higher-priority input is left alone
        wr(8'h29, 8'h21);
        lost <= 4'h0;
        step(12);
        cmp("no_revert", 2, sel);
        // Lock qualification by window timer, then by slip indicator
        wr(8'h28, 8'h02);
        step(6);
        win <= 1;
        repeat (2) @(posedge crt);
        @(posedge clk);
        cmp("early_lock", 0, locked);
        repeat (4) @(posedge crt);
        step(4);
        cmp("lock", 1, locked);
        win <= 0;
        step(6);
        cmp("unlock", 0, locked);
        wr(8'h28, 8'h22);
        repeat (6) @(posedge crt);
        step(4);
        cmp("slip_lock", 1, locked);
        slip <= 1;
        step(6);
        cmp("slip_unlock", 0, locked);
        conclude;
    end
endmodule // testbench

bind dual_loop_ref_switch_config loop_cfg_checker chk_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
    .REF_SEL(REF_SEL), .HOLDOVER(HOLDOVER), .FIRST_LOOP_PUMP_TRISTATE(FIRST_LOOP_PUMP_TRISTATE),
    .HOLDOVER_DAC_EN(HOLDOVER_DAC_EN), .FIRST_LOOP_LOCKED(FIRST_LOOP_LOCKED), .DOUBLER_EN(DOUBLER_EN),
    .SECOND_LOOP_REF_RATIO(SECOND_LOOP_REF_RATIO), .SECOND_LOOP_FB_DIV(SECOND_LOOP_FB_DIV),
    .PUMP_CURRENT_LEVEL(PUMP_CURRENT_LEVEL));
`default_nettype wire
